// ==== pkg/dram_pkg.sv ====
// Shared constants and carrier types for the dual-rank DDR4 device model
package dram_pkg;
  // Organisation
  localparam int RANKS           = 2;
  localparam int BANK_GROUPS     = 4;
  localparam int BANKS_PER_GROUP = 4;
  localparam int BANK_SLOTS      = RANKS * BANK_GROUPS * BANKS_PER_GROUP;
  localparam int ROW_W_X4        = 18;
  localparam int ROW_W_X8        = 17;
  localparam int COL_W           = 10;
  localparam int BURST_LEN       = 8;
  localparam int BURST_CLOCKS    = BURST_LEN / 2;
  localparam int PRECHARGE_ALL_BIT = 10;

  // Link timing at the fastest grade: period in ps, latencies in link clocks
  localparam int CK_PERIOD_PS    = 625;
  localparam int CAS_LAT         = 22;
  localparam int WRITE_LAT       = 16;

  // Refresh obligations of the controller, kept for reference by the bench
  localparam int REFRESH_CMDS      = 8192;
  localparam int REFRESH_WIN_MS    = 64;
  localparam int REFRESH_WIN_HOT_MS = 32;
  localparam int REFRESH_INT_HOT_NS = 3900;
  localparam int HOT_CASE_DEG_C     = 85;

  // Event slots passed from the link side to the system side
  localparam int EV_ACT  = 0;
  localparam int EV_RD   = 1;
  localparam int EV_WR   = 2;
  localparam int EV_REF  = 3;
  localparam int EV_ERR  = 4;
  localparam int EV_NUM  = 5;
  localparam int COUNT_W = 16;

  // Command and address pins sampled on the rising link clock
  typedef struct packed {
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [17:0] addr;
  } cmd_pins_t;

  typedef enum logic [2:0] {
    DIR_IDLE  = 3'b001,
    DIR_READ  = 3'b010,
    DIR_WRITE = 3'b100
  } dir_t;
endpackage : dram_pkg

// ==== hw/dram_rank_pair.sv ====
// Dual-rank DDR4 device: command decode, open-row tracking, DDR bursts, status
// Contract
// - Two ranks, each with its own chip select, termination and clock enable.
// - Each rank has four bank groups of four banks, chosen by BG and BA.
// - In x4 mode rows use A[17:0], columns A[9:0].
// - In x8 mode rows use A[16:0], columns A[9:0].
// - Two data words per clock, backed by an eight-deep core fetch.
// - One 8n-bit core transfer per access, eight half-clock pin transfers.
// - Data travels with a differential strobe from the sender; receiver captures with it. Writes here are captured on dqs_t_in alone.
// - On reads the device aligns data transitions to its strobe edges.
// - Bursts start at the chosen column and follow programmed count and order; here the count is fixed at eight.
// - Activate uses sampled bank group, bank and address to open a row.
// - Read or write uses chip selects, bank and address for rank, bank, column.
// - Clock period 0.625 ns, read data 22 clocks after the read command.
`timescale 1ns/100ps
module dram_rank_pair #(
  parameter int DQ_W      = 8,
  parameter int ST_ROW_W  = 2,
  parameter int ST_COL_W  = 7,
  parameter int CAS_LAT   = dram_pkg::CAS_LAT,
  parameter int WRITE_LAT = dram_pkg::WRITE_LAT
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      cfg_x8,
  input  wire logic                      cfg_interleave,
  input  wire logic                      err_clr,
  input  wire logic                      ck_link,
  input  wire logic [1:0]                cs_n,
  input  wire logic [1:0]                cke,
  input  wire logic [1:0]                odt,
  input  wire dram_pkg::cmd_pins_t       cmd,
  input  wire logic [DQ_W-1:0]           dq_in,
  output logic [DQ_W-1:0]                dq_out,
  output logic                           dq_oe,
  input  wire logic                      dqs_t_in,
  output logic                           dqs_t_out,
  output logic                           dqs_c_out,
  output logic                           dqs_oe,
  output logic [1:0]                     term_on,
  output logic                           mode_x8,
  output logic                           access_err,
  output logic [dram_pkg::COUNT_W-1:0]   act_count,
  output logic [dram_pkg::COUNT_W-1:0]   read_count,
  output logic [dram_pkg::COUNT_W-1:0]   write_count,
  output logic [dram_pkg::COUNT_W-1:0]   refresh_count
);
  localparam int BANK_W  = $clog2(dram_pkg::BANK_SLOTS);
  localparam int IDX_W   = BANK_W + ST_ROW_W + ST_COL_W;
  localparam int WORD_W  = dram_pkg::BURST_LEN * DQ_W;
  localparam int CNT_W   = 7;
  // First read beat leaves on the CAS_LAT-th link edge after the command
  localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(CAS_LAT + dram_pkg::BURST_CLOCKS - 1);
  localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WRITE_LAT + dram_pkg::BURST_CLOCKS + 1);
  localparam logic [CNT_W-1:0] BURST_CNT = CNT_W'(dram_pkg::BURST_CLOCKS);

  // ---------------- System side: configuration ----------------
  logic x8_s1, x8_s2, il_s1, il_s2, interleave;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {x8_s2, x8_s1, il_s2, il_s1} <= 4'h0;
      mode_x8    <= 1'b0;
      interleave <= 1'b0;
    end else if (ce) begin
      {x8_s2, x8_s1} <= {x8_s1, cfg_x8};
      {il_s2, il_s1} <= {il_s1, cfg_interleave};
      mode_x8    <= x8_s2;
      interleave <= il_s2;
    end
  end

  // ---------------- Link side: reset and configuration crossing ----------------
  logic rl0, rl1;
  wire  rst_link = rl1;

  always_ff @(posedge ck_link or posedge rst) begin
    if (rst) {rl1, rl0} <= 2'b11;
    else     {rl1, rl0} <= {rl0, 1'b0};
  end

  logic lx8_s1, lx8, lil_s1, lil;

  always_ff @(posedge ck_link or posedge rst_link) begin
    if (rst_link) {lx8, lx8_s1, lil, lil_s1} <= 4'h0;
    else          {lx8, lx8_s1, lil, lil_s1} <= {lx8_s1, mode_x8, lil_s1, interleave};
  end

  // ---------------- Link side: command decode ----------------
  wire [1:0] rank_hit = ~cs_n & cke;
  wire       cmd_valid = |rank_hit;
  wire       rank_sel  = ~rank_hit[0];
  wire       is_act = cmd_valid & ~cmd.act_n;
  wire       is_cas = cmd_valid & cmd.act_n & cmd.ras_n & ~cmd.cas_n;
  wire       is_rd  = is_cas & cmd.we_n;
  wire       is_wr  = is_cas & ~cmd.we_n;
  wire       is_pre = cmd_valid & cmd.act_n & ~cmd.ras_n & cmd.cas_n & ~cmd.we_n;
  wire       is_ref = cmd_valid & cmd.act_n & ~cmd.ras_n & ~cmd.cas_n & cmd.we_n;
  wire [BANK_W-1:0] bank_idx = {rank_sel, cmd.bg, cmd.ba};
  wire [dram_pkg::ROW_W_X4-1:0] row_in = lx8 ?
         {1'b0, cmd.addr[dram_pkg::ROW_W_X8-1:0]} :
         cmd.addr[dram_pkg::ROW_W_X4-1:0];
  wire [dram_pkg::COL_W-1:0] col_in = cmd.addr[dram_pkg::COL_W-1:0];

  logic [dram_pkg::BANK_SLOTS-1:0] open_valid;
  logic [dram_pkg::ROW_W_X4-1:0]   open_row [dram_pkg::BANK_SLOTS];
  dram_pkg::dir_t                  dir;
  logic [CNT_W-1:0]                cnt;

  wire bank_open = open_valid[bank_idx];
  wire idle      = (dir == dram_pkg::DIR_IDLE);
  wire take_rd   = is_rd & bank_open & idle;
  wire take_wr   = is_wr & bank_open & idle;
  // Closed bank or busy data bus: access is dropped and reported
  wire bad_access = is_cas & ~(bank_open & idle);

  // Open-row table, precharge closes one bank or the whole rank
  always_ff @(posedge ck_link or posedge rst_link) begin
    if (rst_link) begin
      open_valid <= '0;
    end else if (is_act) begin
      open_valid[bank_idx] <= 1'b1;
    end else if (is_pre) begin
      for (int b = 0; b < dram_pkg::BANK_SLOTS; b++) begin
        if ((b / (dram_pkg::BANK_SLOTS / 2)) == int'(rank_sel) &&
            (cmd.addr[dram_pkg::PRECHARGE_ALL_BIT] || b == int'(bank_idx))) begin
          open_valid[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ck_link) begin
    if (is_act) open_row[bank_idx] <= row_in;
  end

  // ---------------- Link side: burst sequencing ----------------
  logic [BANK_W-1:0]         acc_bank;
  logic [ST_ROW_W-1:0]       acc_row;
  logic [dram_pkg::COL_W-1:0] acc_col;

  wire [CNT_W-1:0] next_cnt = cnt - CNT_W'(1);
  wire             last_clk = (cnt == CNT_W'(1));

  always_ff @(posedge ck_link or posedge rst_link) begin
    if (rst_link) begin
      dir      <= dram_pkg::DIR_IDLE;
      cnt      <= '0;
      acc_bank <= '0;
      acc_row  <= '0;
      acc_col  <= '0;
    end else begin
      case (dir)
        dram_pkg::DIR_IDLE: begin
          if (take_rd || take_wr) begin
            dir      <= take_rd ? dram_pkg::DIR_READ : dram_pkg::DIR_WRITE;
            cnt      <= take_rd ? RD_LOAD : WR_LOAD;
            acc_bank <= bank_idx;
            acc_row  <= open_row[bank_idx][ST_ROW_W-1:0];
            acc_col  <= col_in;
          end
        end
        dram_pkg::DIR_READ,
        dram_pkg::DIR_WRITE: begin
          cnt <= next_cnt;
          if (last_clk) dir <= dram_pkg::DIR_IDLE;
        end
        default: dir <= dram_pkg::DIR_IDLE;
      endcase
    end
  end

  // ---------------- Core array: one 8n-bit word per access ----------------
  logic [WORD_W-1:0] core [2**IDX_W];
  wire  [IDX_W-1:0]  core_idx = {acc_bank, acc_row, acc_col[dram_pkg::COL_W-1 -: ST_COL_W]};
  wire  [2:0]        start    = acc_col[2:0];
  wire  [WORD_W-1:0] rd_word  = core[core_idx];
  wire  [DQ_W-1:0]   lane_mask = lx8 ? {DQ_W{1'b1}} : {{(DQ_W/2){1'b0}}, {(DQ_W/2){1'b1}}};

  // Burst position of pin beat i: sequential wrap or interleaved
  function automatic logic [2:0] beat_pos(input logic [2:0] s, input logic [2:0] i, input logic il);
    beat_pos = il ? (s ^ i) : 3'(s + i);
  endfunction : beat_pos

  // Write capture on the incoming strobe; the last four of each edge hold the burst
  logic [DQ_W-1:0] cap_r [4];
  logic [DQ_W-1:0] cap_f [4];

  always_ff @(posedge dqs_t_in) begin
    for (int k = 0; k < 3; k++) cap_r[k] <= cap_r[k + 1];
    cap_r[3] <= dq_in;
  end

  always_ff @(negedge dqs_t_in) begin
    for (int k = 0; k < 3; k++) cap_f[k] <= cap_f[k + 1];
    cap_f[3] <= dq_in;
  end

  // Strobe is idle by commit time, so the capture registers are stable here
  logic [WORD_W-1:0] wr_word;

  always_comb begin
    wr_word = '0;
    for (int m = 0; m < dram_pkg::BURST_CLOCKS; m++) begin
      wr_word[beat_pos(start, 3'(2*m), lil)*DQ_W +: DQ_W]   = cap_r[m] & lane_mask;
      wr_word[beat_pos(start, 3'(2*m+1), lil)*DQ_W +: DQ_W] = cap_f[m] & lane_mask;
    end
  end

  wire commit_wr = (dir == dram_pkg::DIR_WRITE) & last_clk;

  always_ff @(posedge ck_link) begin
    if (commit_wr) core[core_idx] <= wr_word;
  end

  // ---------------- Read drive: two words per clock ----------------
  wire       rd_phase = (dir == dram_pkg::DIR_READ) & (cnt <= BURST_CNT) & (cnt != '0);
  wire [1:0] pair     = 2'(BURST_CNT - cnt);
  wire [2:0] pos_even = beat_pos(start, {pair, 1'b0}, lil);
  wire [2:0] pos_odd  = beat_pos(start, {pair, 1'b1}, lil);

  logic            drv;
  logic [DQ_W-1:0] beat_even, beat_odd, beat_odd_f;

  always_ff @(posedge ck_link or posedge rst_link) begin
    if (rst_link) begin
      drv       <= 1'b0;
      beat_even <= '0;
      beat_odd  <= '0;
    end else begin
      drv       <= rd_phase;
      beat_even <= rd_phase ? rd_word[pos_even*DQ_W +: DQ_W] & lane_mask : '0;
      beat_odd  <= rd_phase ? rd_word[pos_odd*DQ_W +: DQ_W] & lane_mask : '0;
    end
  end

  always_ff @(negedge ck_link or posedge rst_link) begin
    if (rst_link) beat_odd_f <= '0;
    else          beat_odd_f <= beat_odd;
  end

  // Data and strobe both switch on each link clock edge
  assign dq_out    = ck_link ? beat_even : beat_odd_f;
  assign dq_oe     = drv;
  assign dqs_t_out = drv & ck_link;
  assign dqs_c_out = ~(drv & ck_link);
  assign dqs_oe    = drv;

  // Termination follows each rank's own enable and clock-enable pins
  always_ff @(posedge ck_link or posedge rst_link) begin
    if (rst_link) term_on <= 2'b00;
    else          term_on <= odt & cke;
  end

  // ---------------- Events to the system side ----------------
  logic [dram_pkg::EV_NUM-1:0] ev_tog;
  wire  [dram_pkg::EV_NUM-1:0] ev_hit;

  assign ev_hit[dram_pkg::EV_ACT] = is_act;
  assign ev_hit[dram_pkg::EV_RD]  = take_rd;
  assign ev_hit[dram_pkg::EV_WR]  = take_wr;
  assign ev_hit[dram_pkg::EV_REF] = is_ref;
  assign ev_hit[dram_pkg::EV_ERR] = bad_access;

  always_ff @(posedge ck_link or posedge rst_link) begin
    if (rst_link) ev_tog <= '0;
    else          ev_tog <= ev_tog ^ ev_hit;
  end

  logic [dram_pkg::EV_NUM-1:0] ev_s1, ev_s2, ev_s3;
  logic [dram_pkg::COUNT_W-1:0] ev_cnt [dram_pkg::EV_NUM];
  wire  [dram_pkg::EV_NUM-1:0] ev_pulse = ev_s2 ^ ev_s3;

  // Toggles survive a stopped link clock; one event per two link clocks at most
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {ev_s3, ev_s2, ev_s1} <= '0;
    end else if (ce) begin
      {ev_s3, ev_s2, ev_s1} <= {ev_s2, ev_s1, ev_tog};
    end
  end

  genvar e;
  generate
    for (e = 0; e < dram_pkg::EV_NUM; e++) begin : g_count
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)                   ev_cnt[e] <= '0;
        else if (ce && ev_pulse[e]) ev_cnt[e] <= ev_cnt[e] + dram_pkg::COUNT_W'(1);
      end
    end
  endgenerate

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)     access_err <= 1'b0;
    else if (ce) access_err <= ev_pulse[dram_pkg::EV_ERR] | (access_err & ~err_clr);
  end

  assign act_count     = ev_cnt[dram_pkg::EV_ACT];
  assign read_count    = ev_cnt[dram_pkg::EV_RD];
  assign write_count   = ev_cnt[dram_pkg::EV_WR];
  assign refresh_count = ev_cnt[dram_pkg::EV_REF];
endmodule : dram_rank_pair

// ==== verif/dram_props.sv ====
// Port checker for the dual-rank device
`timescale 1ns/100ps
module dram_props #(
  parameter int CAS_LAT = 22
) (
  input wire logic                          clk_sys,
  input wire logic                          rst,
  input wire logic                          err_clr,
  input wire logic                          ck_link,
  input wire logic [1:0]                    cs_n,
  input wire logic [1:0]                    cke,
  input wire logic [1:0]                    odt,
  input wire dram_pkg::cmd_pins_t           cmd,
  input wire logic                          dq_oe,
  input wire logic                          dqs_t_out,
  input wire logic                          dqs_c_out,
  input wire logic                          dqs_oe,
  input wire logic [1:0]                    term_on,
  input wire logic                          access_err,
  input wire logic [dram_pkg::COUNT_W-1:0]  read_count
);
  wire       sel = (!cs_n[0] && cke[0]) || (!cs_n[1] && cke[1]);
  wire       rd = sel && cmd.act_n && cmd.ras_n && !cmd.cas_n && cmd.we_n;
  wire [1:0] term_req = odt & cke;

  property p_oe_pair; @(posedge ck_link) disable iff (rst) dq_oe == dqs_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("data and strobe enables differ");
  property p_burst_len; @(posedge ck_link) disable iff (rst) $rose(dq_oe) |-> dq_oe [*4] ##1 !dq_oe; endproperty
  a_burst_len: assert property (p_burst_len) else $error("read drive not four clocks");
  property p_read_lat; @(posedge ck_link) disable iff (rst) $rose(dq_oe) |-> $past(rd, CAS_LAT + 1); endproperty
  a_read_lat: assert property (p_read_lat) else $error("read drive without read at latency");
  property p_strobe_hi; @(negedge ck_link) disable iff (rst) dqs_oe |-> dqs_t_out && !dqs_c_out; endproperty
  a_strobe_hi: assert property (p_strobe_hi) else $error("strobe not high in first half");
  property p_strobe_lo; @(posedge ck_link) disable iff (rst) dqs_oe |-> !dqs_t_out && dqs_c_out; endproperty
  a_strobe_lo: assert property (p_strobe_lo) else $error("strobe not low in second half");
  property p_term; @(posedge ck_link) disable iff (rst) term_on == $past(term_req); endproperty
  a_term: assert property (p_term) else $error("termination does not follow request");
  property p_err_hold; @(posedge clk_sys) disable iff (rst) access_err && !err_clr |=> access_err; endproperty
  a_err_hold: assert property (p_err_hold) else $error("access error lost");
  property p_rd_step;
    @(posedge clk_sys) disable iff (rst) read_count != $past(read_count) |-> read_count == $past(read_count) + 16'h1;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read count jumped");
  c_read: cover property (@(posedge ck_link) $rose(dq_oe));
  c_err: cover property (@(posedge clk_sys) $rose(access_err));
  c_term: cover property (@(posedge ck_link) $rose(term_on[1]));
endmodule : dram_props

bind dram_rank_pair dram_props #(.CAS_LAT(CAS_LAT)) dram_props_inst (
  .clk_sys(clk_sys), .rst(rst), .err_clr(err_clr), .ck_link(ck_link), .cs_n(cs_n), .cke(cke), .odt(odt),
  .cmd(cmd), .dq_oe(dq_oe), .dqs_t_out(dqs_t_out), .dqs_c_out(dqs_c_out), .dqs_oe(dqs_oe),
  .term_on(term_on), .access_err(access_err), .read_count(read_count));

// ==== verif/host_model.sv ====
// Host controller model for the link pins
`timescale 1ns/100ps
module host_model (
  input  wire logic           ck_link,
  output dram_pkg::cmd_pins_t cmd,
  output logic [1:0]          cs_n,
  output logic [1:0]          cke,
  output logic [1:0]          odt,
  output logic [7:0]          dq_in,
  output logic                dqs_t_in
);
  initial begin
    cmd = {4'hf, 22'h000000};
    cs_n = 2'h3;
    cke = 2'h3;
    odt = 2'h0;
    dq_in = 8'h00;
    dqs_t_in = 1'b0;
  end

  task automatic send(input logic rank, input logic [3:0] kind, input logic [3:0] bank, input logic [17:0] addr);
    @(posedge ck_link);
    cs_n <= rank ? 2'h1 : 2'h2;
    cmd <= {kind, bank, addr};
    @(posedge ck_link);
    cs_n <= 2'h3;
    cmd <= {4'hf, ~bank, ~addr}; // Released pins show no stale value
  endtask : send

  task automatic write_burst(input logic [63:0] data);
    repeat (dram_pkg::WRITE_LAT) @(posedge ck_link);
    for (int i = 0; i < 8; i++) begin
      dq_in <= data[i*8 +: 8];
      #8 dqs_t_in = ~dqs_t_in;
      #8;
    end
    dq_in <= ~data[63:56];
    repeat (3) @(posedge ck_link);
  endtask : write_burst

  task automatic set_odt(input logic [1:0] v);
    @(posedge ck_link);
    odt <= v;
  endtask : set_odt

  // Refresh pacing; the average gap halves above the hot case threshold
  localparam int LINK_NS = 32;
  logic          srt_on  = 1'b0;

  task automatic refresh(input logic rank, input logic hot);
    int gap_ns;
    gap_ns = dram_pkg::REFRESH_WIN_MS * 1000000 / dram_pkg::REFRESH_CMDS;
    if (hot)
      gap_ns = dram_pkg::REFRESH_INT_HOT_NS;
    srt_on = hot;
    send(rank, 4'h9, 4'h0, 18'h00000);
    repeat (gap_ns / LINK_NS - 2) @(posedge ck_link);
  endtask : refresh
endmodule : host_model

// ==== verif/tb.sv ====
// Self-checking bench for the dual-rank device
`timescale 1ns/100ps
module tb;
  localparam logic [3:0] ACT = 4'h7;
  localparam logic [3:0] RD = 4'hd;
  localparam logic [3:0] WR = 4'hc;
  localparam logic [3:0] REF = 4'h9;
  localparam logic [3:0] PRE = 4'ha;
  logic                clk_sys = 1'b0;
  logic                ck_link = 1'b0;
  logic                rst = 1'b1;
  logic                cfg_interleave = 1'b0;
  logic                cfg_x8 = 1'b1;
  logic                err_clr = 1'b0;
  logic [1:0]          cs_n, cke, odt, term_on;
  logic [7:0]          dq_in, dq_out;
  logic                dq_oe, dqs_t_in, dqs_t_out, dqs_c_out, dqs_oe, mode_x8, access_err;
  logic [15:0]         act_count, read_count, write_count, refresh_count;
  dram_pkg::cmd_pins_t cmd;
  int                  errors = 0;
  int                  checks_done = 0;
  int                  cycles = 0;

  always #12.5 clk_sys = ~clk_sys;
  always #16 ck_link = ~ck_link;

  host_model host_model_inst (.ck_link(ck_link), .cmd(cmd), .cs_n(cs_n), .cke(cke), .odt(odt),
    .dq_in(dq_in), .dqs_t_in(dqs_t_in));
  dram_rank_pair dram_rank_pair_inst (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .cfg_x8(cfg_x8), .cfg_interleave(cfg_interleave),
    .err_clr(err_clr), .ck_link(ck_link), .cs_n(cs_n), .cke(cke), .odt(odt), .cmd(cmd),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_t_in(dqs_t_in), .dqs_t_out(dqs_t_out),
    .dqs_c_out(dqs_c_out), .dqs_oe(dqs_oe), .term_on(term_on), .mode_x8(mode_x8),
    .access_err(access_err), .act_count(act_count), .read_count(read_count),
    .write_count(write_count), .refresh_count(refresh_count));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_sys(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : wait_sys

  // A second read issued while the first read is still pending must be dropped
  task automatic read_chk(input logic rank, input logic [2:0] col, input logic [63:0] word, input logic dup);
    logic [2:0] pos;
    host_model_inst.send(rank, RD, 4'h9, {15'h0000, col});
    if (dup)
      host_model_inst.send(rank, RD, 4'h9, 18'h00000);
    repeat (dup ? dram_pkg::CAS_LAT - 2 : dram_pkg::CAS_LAT) @(posedge ck_link);
    for (int i = 0; i < 8; i++) begin
      pos = cfg_interleave ? col ^ 3'(i) : col + 3'(i);
      #8;
      check(64'(dq_oe), 64'h1);
      check(64'(dq_out), 64'(word[pos*8 +: 8]));
      #8;
    end
    repeat (3) @(posedge ck_link);
  endtask : read_chk

  task automatic t_data();
    host_model_inst.send(1'b1, ACT, 4'h9, 18'h2abcd);
    host_model_inst.send(1'b1, WR, 4'h9, 18'h00000);
    host_model_inst.write_burst(64'h8877665544332211);
    host_model_inst.send(1'b0, ACT, 4'h9, 18'h2abcd);
    host_model_inst.send(1'b0, WR, 4'h9, 18'h00000);
    host_model_inst.write_burst(64'h0f1e2d3c4b5a6978);
    read_chk(1'b1, 3'h3, 64'h8877665544332211, 1'b1);
    @(posedge clk_sys) cfg_interleave <= 1'b1;
    wait_sys(20);
    read_chk(1'b0, 3'h5, 64'h0f1e2d3c4b5a6978, 1'b0);
    $display("data test done");
  endtask : t_data

  task automatic t_status();
    wait_sys(10);
    check(64'(access_err), 64'h1);
    check(64'({read_count, write_count, act_count}), 64'h000200020002);
    @(posedge clk_sys) err_clr <= 1'b1;
    @(posedge clk_sys) err_clr <= 1'b0;
    wait_sys(2);
    check(64'(access_err), 64'h0);
    host_model_inst.send(1'b0, RD, 4'hf, 18'h00000);
    host_model_inst.send(1'b0, REF, 4'h0, 18'h00000);
    wait_sys(10);
    check(64'({access_err, read_count}), 64'h10002);
    check(64'(refresh_count), 64'h1);
    host_model_inst.refresh(1'b0, 1'b0);
    host_model_inst.refresh(1'b1, 1'b1);
    wait_sys(10);
    check(64'(refresh_count), 64'h3);
    host_model_inst.set_odt(2'h2);
    repeat (2) @(posedge ck_link);
    #4 check(64'(term_on), 64'h2);
    $display("status test done");
  endtask : t_status

  // Narrow mode: upper lanes of the stored word read back as zero
  task automatic t_narrow();
    @(posedge clk_sys) cfg_x8 <= 1'b0;
    wait_sys(20);
    check(64'(mode_x8), 64'h0);
    read_chk(1'b0, 3'h5, 64'h0f0e0d0c0b0a0908, 1'b0);
    $display("narrow test done");
  endtask : t_narrow

  // Precharge of all rank 0 banks makes the next read a refused access
  task automatic t_close();
    @(posedge clk_sys) err_clr <= 1'b1;
    @(posedge clk_sys) err_clr <= 1'b0;
    host_model_inst.send(1'b0, PRE, 4'h0, 18'h00400);
    host_model_inst.send(1'b0, RD, 4'h9, 18'h00000);
    wait_sys(10);
    check(64'({access_err, read_count}), 64'h10003);
    $display("close test done");
  endtask : t_close

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // Guards against a hung run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    wait_sys(8);
    check(64'(mode_x8), 64'h1);
    check(64'({dq_oe, term_on, access_err, read_count}), 64'h0);
    $display("reset test done");
    t_data();
    t_status();
    t_narrow();
    t_close();
    give_verdict();
  end
endmodule : tb
